// ===== verilog/ascc_defs.svh
// offsets, field positions, reset values and counts for the serial configuration port
// included by the package and the design modules
`ifndef ASCC_DEFS_SVH
`define ASCC_DEFS_SVH

`define ASCC_WORD_W 20
`define ASCC_CNT_W 5
`define ASCC_ADDR_W 9
`define ASCC_DATA_W 8
`define ASCC_OP_W 3

// command word layout
`define ASCC_OP_MSB 19
`define ASCC_OP_LSB 17
`define ASCC_ADDR_MSB 16
`define ASCC_ADDR_LSB 8
`define ASCC_DATA_MSB 7
`define ASCC_DATA_LSB 0

// register offsets
`define ASCC_ADDR_LOW_POWER 9'h010
`define ASCC_ADDR_UNLOCK 9'h011
`define ASCC_ADDR_IN_PROTO 9'h014
`define ASCC_ADDR_OUT_PROTO 9'h018
`define ASCC_ADDR_WORD_CFG 9'h01C
`define ASCC_UNLOCK_KEY 8'h69

// field positions and write masks
`define ASCC_POWER_DOWN_BIT 0
`define ASCC_LIGHT_SLEEP_BIT 1
`define ASCC_LOW_POWER_MASK 8'h03
`define ASCC_IN_PROTO_MASK 8'h03
`define ASCC_OUT_PROTO_MASK 8'hDF
`define ASCC_WORD_CFG_MASK 8'h3F
`define ASCC_OUT_MODE_MASK 8'h03

// reset values
`define ASCC_RST_REG 8'h00

`endif

// ===== verilog/ascc_pkg.sv
// types shared by the serial configuration port modules
// expects ascc_defs.svh on the include path
`include "ascc_defs.svh"

package ascc_pkg;

  typedef enum logic [2:0] {
    ASCC_OP_NOP = 3'h0,
    ASCC_OP_RD = 3'h4,
    ASCC_OP_WR = 3'h5
  } ascc_op_t;

  typedef enum logic {
    ASCC_FR_IDLE = 1'b0,
    ASCC_FR_SHIFT = 1'b1
  } ascc_frame_t;

  typedef struct packed {
    ascc_frame_t frame;
    logic [`ASCC_WORD_W-1:0] combined_shift_register;
    logic [`ASCC_WORD_W-1:0] sample;
    logic [`ASCC_CNT_W-1:0] cnt;
    logic rd_pend;
    logic [`ASCC_DATA_W-1:0] rd_data;
    logic unlock;
    logic [`ASCC_DATA_W-1:0] low_power;
    logic [`ASCC_DATA_W-1:0] in_proto;
    logic [`ASCC_DATA_W-1:0] out_proto;
    logic [`ASCC_DATA_W-1:0] word_cfg;
    logic sdo;
    logic sdo_oe;
    logic ready;
    logic sample_pulse;
  } ascc_state_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic conv;
  } ascc_edge_state_t;

endpackage

// ===== verilog/ascc_edge_if.sv
// edge events from the pin sampler to the port logic, and the protocol it needs back
// single clock domain, no clocking block
`timescale 1ns/1ps
interface ascc_edge_if;
  logic cpol;
  logic cpha;
  logic launch;
  logic capture;
  logic frame_start;
  logic frame_end;
  logic conv_rise;

  modport src (input cpol, input cpha, output launch, output capture, output frame_start, output frame_end,
    output conv_rise);
  modport snk (output cpol, output cpha, input launch, input capture, input frame_start, input frame_end,
    input conv_rise);
endinterface

// ===== verilog/ascc_edge_detect.sv
// pin edge detector: serial clock launch and capture, chip select and conversion start edges
// pins are synchronous to clk_i
`timescale 1ns/1ps
`include "ascc_defs.svh"

module ascc_edge_detect (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // host pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic conv_start_i,
  // events
  ascc_edge_if.src ev
);

  ascc_pkg::ascc_edge_state_t s_q;
  ascc_pkg::ascc_edge_state_t s_d;
  logic lead;
  logic trail;

  always_comb begin
    s_d.sclk = sclk_i;
    s_d.cs_n = cs_n_i;
    s_d.conv = conv_start_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // conv history starts high: a pin tied to select shows no rise after reset
      s_q <= '{sclk: 1'b0, cs_n: 1'b1, conv: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // leading edge leaves the idle level set by polarity
  always_comb begin
    lead = !cs_n_i && (sclk_i != s_q.sclk) && (s_q.sclk == ev.cpol);
    trail = !cs_n_i && (sclk_i != s_q.sclk) && (s_q.sclk != ev.cpol);
  end

  assign ev.capture = ev.cpha ? trail : lead;
  assign ev.launch = ev.cpha ? lead : trail;
  assign ev.frame_start = s_q.cs_n && !cs_n_i;
  assign ev.frame_end = !s_q.cs_n && cs_n_i;
  assign ev.conv_rise = !s_q.conv && conv_start_i;

endmodule

// ===== verilog/ascc_port.sv
// serial host port and configuration registers of a converter, chainable
// how it works: samples pins on clk_i, the host serial clock is far slower than clk_i
//
// How it works
// - output and input words share one register
// - sample taken at conversion start rising edge
// - frame opens on chip select falling
// - launch edge drives shift register MSB out
// - capture edge shifts serial input into LSB
// - chip select rising executes held command after a full frame
// - registers at 010h, 014h, 018h, 01Ch
// - low-power write needs prior 69h key
// - low-power bit 1 enables light sleep
// - low-power bit 0 powers the device down
// - reserved bits read zero
// - input field selects clock polarity and phase
// - works with conversion start tied to select
// - read-out follows input protocol when mode zero
`timescale 1ns/1ps
`include "ascc_defs.svh"

module ascc_port #(
  parameter int RES_W = 18
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // host serial pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  input wire logic conv_start_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic ready_strobe_out_o,
  // converter core
  input wire logic [RES_W-1:0] conv_result_i,
  output logic sample_o,
  output logic light_sleep_enable_o,
  output logic power_down_bit_o,
  output logic [1:0] output_mode_field_o,
  output logic [7:0] output_word_config_o
);

  // refuse parameters the word layout cannot hold
  if (RES_W < 1 || RES_W > `ASCC_WORD_W - 2) begin : g_bad_res_w
    $error("RES_W out of range");
  end
  if ((1 << `ASCC_CNT_W) <= `ASCC_WORD_W) begin : g_bad_cnt_w
    $error("bit counter too narrow for one word");
  end

  ascc_edge_if ev ();

  ascc_pkg::ascc_state_t s_q;
  ascc_pkg::ascc_state_t s_d;
  logic [`ASCC_WORD_W-1:0] load_word;
  logic [`ASCC_OP_W-1:0] op;
  logic [`ASCC_ADDR_W-1:0] addr;
  logic [`ASCC_DATA_W-1:0] wdata;
  logic [`ASCC_DATA_W-1:0] rdata;
  logic full_frame;
  logic cmd_exec;
  logic cmd_wr;
  logic cmd_rd;
  logic wr_unlock;
  logic wr_low_power;
  logic wr_in_proto;
  logic wr_out_proto;
  logic wr_word_cfg;

  // state after reset: idle frame, all registers cleared, port ready
  localparam ascc_pkg::ascc_state_t RST_STATE = '{
    frame: ascc_pkg::ASCC_FR_IDLE,
    combined_shift_register: '0,
    sample: '0,
    cnt: '0,
    rd_pend: 1'b0,
    rd_data: `ASCC_RST_REG,
    unlock: 1'b0,
    low_power: `ASCC_RST_REG,
    in_proto: `ASCC_RST_REG,
    out_proto: `ASCC_RST_REG,
    word_cfg: `ASCC_RST_REG,
    sdo: 1'b0,
    sdo_oe: 1'b0,
    ready: 1'b1,
    sample_pulse: 1'b0
  };

  ascc_edge_detect u_edge (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .cs_n_i(cs_n_i),
    .sclk_i(sclk_i),
    .conv_start_i(conv_start_i),
    .ev(ev)
  );

  // a new mode applies only once the frame that wrote it has closed
  assign ev.cpol = s_q.in_proto[1];
  assign ev.cpha = s_q.in_proto[0];

  always_comb begin
    op = s_q.combined_shift_register[`ASCC_OP_MSB:`ASCC_OP_LSB];
    addr = s_q.combined_shift_register[`ASCC_ADDR_MSB:`ASCC_ADDR_LSB];
    wdata = s_q.combined_shift_register[`ASCC_DATA_MSB:`ASCC_DATA_LSB];
    full_frame = s_q.cnt == 5'(`ASCC_WORD_W);
    // pending register read goes out in the upper byte, else the sample
    if (s_q.rd_pend) begin
      load_word = {s_q.rd_data, {(`ASCC_WORD_W - `ASCC_DATA_W){1'b0}}};
    end else begin
      load_word = s_q.sample;
    end
    unique case (addr)
      `ASCC_ADDR_LOW_POWER: rdata = s_q.low_power;
      `ASCC_ADDR_IN_PROTO: rdata = s_q.in_proto;
      `ASCC_ADDR_OUT_PROTO: rdata = s_q.out_proto;
      `ASCC_ADDR_WORD_CFG: rdata = s_q.word_cfg;
      default: rdata = `ASCC_RST_REG;
    endcase
  end

  // command decode, live only in the cycle a full frame closes
  always_comb begin
    cmd_exec = (s_q.frame == ascc_pkg::ASCC_FR_SHIFT) && ev.frame_end && full_frame;
    cmd_wr = cmd_exec && (op == ascc_pkg::ASCC_OP_WR);
    cmd_rd = cmd_exec && (op == ascc_pkg::ASCC_OP_RD);
    wr_unlock = cmd_wr && (addr == `ASCC_ADDR_UNLOCK);
    // the key opens exactly one following full frame
    wr_low_power = cmd_wr && (addr == `ASCC_ADDR_LOW_POWER) && s_q.unlock;
    wr_in_proto = cmd_wr && (addr == `ASCC_ADDR_IN_PROTO);
    wr_out_proto = cmd_wr && (addr == `ASCC_ADDR_OUT_PROTO);
    wr_word_cfg = cmd_wr && (addr == `ASCC_ADDR_WORD_CFG);
  end

  always_comb begin
    s_d = s_q;
    s_d.sample_pulse = 1'b0;
    if (ev.conv_rise) begin
      s_d.sample = {conv_result_i, {(`ASCC_WORD_W - RES_W){1'b0}}};
      s_d.sample_pulse = 1'b1;
    end
    unique case (s_q.frame)
      ascc_pkg::ASCC_FR_IDLE: begin
        s_d.sdo_oe = 1'b0;
        s_d.ready = 1'b1;
        if (ev.frame_start) begin
          s_d.frame = ascc_pkg::ASCC_FR_SHIFT;
          s_d.combined_shift_register = load_word;
          // first bit stands on the pin before the first clock edge
          s_d.sdo = load_word[`ASCC_WORD_W-1];
          s_d.sdo_oe = 1'b1;
          s_d.ready = 1'b0;
          s_d.cnt = '0;
          s_d.rd_pend = 1'b0;
        end
      end
      ascc_pkg::ASCC_FR_SHIFT: begin
        if (ev.capture) begin
          s_d.combined_shift_register = {s_q.combined_shift_register[`ASCC_WORD_W-2:0], sdi_i};
          if (!full_frame) begin
            s_d.cnt = s_q.cnt + 5'h01;
          end
        end
        if (ev.launch) begin
          s_d.sdo = s_q.combined_shift_register[`ASCC_WORD_W-1];
        end
        if (ev.frame_end) begin
          s_d.frame = ascc_pkg::ASCC_FR_IDLE;
          s_d.sdo_oe = 1'b0;
          s_d.ready = 1'b1;
          // short frames are dropped to protect the configuration
          if (cmd_exec) begin
            s_d.unlock = wr_unlock && (wdata == `ASCC_UNLOCK_KEY);
          end
          if (wr_low_power) begin
            s_d.low_power = wdata & `ASCC_LOW_POWER_MASK;
          end
          if (wr_in_proto) begin
            s_d.in_proto = wdata & `ASCC_IN_PROTO_MASK;
          end
          if (wr_out_proto) begin
            s_d.out_proto = wdata & `ASCC_OUT_PROTO_MASK;
          end
          if (wr_word_cfg) begin
            s_d.word_cfg = wdata & `ASCC_WORD_CFG_MASK;
          end
          if (cmd_rd) begin
            s_d.rd_pend = 1'b1;
            s_d.rd_data = rdata;
          end
        end
      end
    endcase
  end

  // asynchronous clear to the idle, ready state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // every output is a register bit, never a decode
  assign sdo_o = s_q.sdo;
  assign sdo_oe_o = s_q.sdo_oe;
  assign ready_strobe_out_o = s_q.ready;
  assign sample_o = s_q.sample_pulse;
  assign light_sleep_enable_o = s_q.low_power[`ASCC_LIGHT_SLEEP_BIT];
  assign power_down_bit_o = s_q.low_power[`ASCC_POWER_DOWN_BIT];
  assign output_mode_field_o = s_q.out_proto[1:0];
  assign output_word_config_o = s_q.word_cfg;

endmodule

// ===== tb/ascc_port_sva.sv
// pin-level assertions for the serial configuration port
// bound to ascc_port, one clock domain
`timescale 1ns/1ps
module ascc_port_sva (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // host pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic conv_start_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_o,
  input wire logic ready_strobe_out_o,
  // core side
  input wire logic sample_o,
  input wire logic light_sleep_enable_o,
  input wire logic power_down_bit_o,
  input wire logic [1:0] output_mode_field_o,
  input wire logic [7:0] output_word_config_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_open; sdo_oe_o && !ready_strobe_out_o; endsequence
  sequence s_pulse; sample_o ##1 !sample_o; endsequence
  property p_open; $fell(cs_n_i) |=> s_open; endproperty
  property p_hold; !cs_n_i && !$past(cs_n_i) |-> s_open; endproperty
  property p_release; cs_n_i && $past(cs_n_i) |-> !sdo_oe_o && ready_strobe_out_o; endproperty
  property p_ready; ready_strobe_out_o != sdo_oe_o; endproperty
  property p_sample; $rose(conv_start_i) |=> s_pulse; endproperty
  property p_cause; sample_o |-> $past(conv_start_i) && !$past(conv_start_i, 2); endproperty
  property p_sdo;
    sdo_oe_o && $past(sdo_oe_o) && $stable(sclk_i) && $past(sclk_i) == $past(sclk_i, 2) |-> $stable(sdo_o);
  endproperty
  property p_regs;
    $changed({light_sleep_enable_o, power_down_bit_o, output_mode_field_o, output_word_config_o})
      |-> $past(cs_n_i) && !$past(cs_n_i, 2);
  endproperty
  a_open: assert property (p_open) else $error("frame did not open");
  a_hold: assert property (p_hold) else $error("frame dropped");
  a_release: assert property (p_release) else $error("output not released");
  a_ready: assert property (p_ready) else $error("ready disagrees");
  a_sample: assert property (p_sample) else $error("no sample pulse");
  a_cause: assert property (p_cause) else $error("stray sample pulse");
  a_sdo: assert property (p_sdo) else $error("output moved without launch");
  a_regs: assert property (p_regs) else $error("register moved outside frame end");
endmodule

// ===== tb/ascc_host_model.sv
// host controller model: chip select, serial clock and data in, reads serial out
// runs off the system clock, each serial clock level held four cycles
`timescale 1ns/1ps
module ascc_host_model (
  // clock
  input wire logic clk_i,
  // serial pins
  input wire logic sdo_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic sdi_o
);
  logic [1:0] mode = 2'h0;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end
  task automatic xfer(input logic [39:0] w, input int n, output logic [39:0] r);
    r = '0;
    sclk_o = mode[1];
    repeat (4) @(negedge clk_i);
    cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      if (!mode[0]) sdi_o = w[i];
      repeat (4) @(negedge clk_i);
      sclk_o = !mode[1];
      if (mode[0]) sdi_o = w[i];
      else r[i] = sdo_i;
      repeat (4) @(negedge clk_i);
      sclk_o = mode[1];
      if (mode[0]) r[i] = sdo_i;
    end
    repeat (4) @(negedge clk_i);
    cs_n_o = 1'b1;
    sdi_o = !sdi_o;
    repeat (4) @(negedge clk_i);
  endtask
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the serial configuration port
// host model drives the serial pins, bench drives conversion start and result
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [8:0] a; logic [7:0] d; logic [7:0] e;} ascc_row_t;
  logic clk_i, rst_n_i, cs_n, sclk, sdi, conv, conv_q, tie, sdo, sdo_oe, ready, sample, sleep, power_down_bit, sdo_line;
  logic [1:0] omode;
  logic [7:0] wcfg;
  logic [17:0] res;
  logic [39:0] r;
  int n_mismatch = 0;
  int cmp_count = 0;
  ascc_row_t rows [8] = '{'{9'h014, 8'hFE, 8'h02}, '{9'h014, 8'hFD, 8'h01}, '{9'h014, 8'hFF, 8'h03},
    '{9'h014, 8'h00, 8'h00}, '{9'h018, 8'hFC, 8'hDC}, '{9'h01C, 8'hFF, 8'h3F}, '{9'h010, 8'h03, 8'h00},
    '{9'h012, 8'h55, 8'h00}};
  assign conv = tie ? cs_n : conv_q;
  // released line has no pull: show the inverse so a late enable is caught
  assign sdo_line = sdo_oe ? sdo : !sdo;
  ascc_host_model u_host (.clk_i(clk_i), .sdo_i(sdo_line), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi));
  ascc_port u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi),
    .conv_start_i(conv), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .ready_strobe_out_o(ready), .conv_result_i(res),
    .sample_o(sample), .light_sleep_enable_o(sleep), .power_down_bit_o(power_down_bit), .output_mode_field_o(omode),
    .output_word_config_o(wcfg));
  task automatic check(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic [39:0] w, input int n);
    u_host.xfer(w, n, r);
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    xfer({20'h0, ascc_pkg::ASCC_OP_WR, a, d}, 20);
  endtask
  task automatic rdchk(input logic [8:0] a, input logic [7:0] e);
    xfer({20'h0, ascc_pkg::ASCC_OP_RD, a, 8'h00}, 20);
    xfer(40'h0, 20);
    check("readback", {12'h0, r[19:12]}, {12'h0, e});
  endtask
  task automatic finish_test;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    repeat (50000) @(posedge clk_i);
    n_mismatch++;
    finish_test();
  end
  initial begin
    rst_n_i = 1'b0;
    tie = 1'b0;
    conv_q = 1'b0;
    res = 18'h0;
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
    check("reset", {6'h0, sdo_oe, ready, sleep, power_down_bit, omode, wcfg}, 20'h01000);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      if (rows[i].a == 9'h014) u_host.mode = rows[i].d[1:0];
      rdchk(rows[i].a, rows[i].e);
    end
    check("outs", {10'h0, omode, wcfg}, 20'h0003F);
    wr(9'h011, 8'h69);
    wr(9'h010, 8'h03);
    check("unlocked", {18'h0, sleep, power_down_bit}, 20'h3);
    wr(9'h010, 8'h00);
    check("relocked", {18'h0, sleep, power_down_bit}, 20'h3);
    wr(9'h011, 8'h69);
    wr(9'h010, 8'h02);
    check("sleep", {18'h0, sleep, power_down_bit}, 20'h2);
    rdchk(9'h010, 8'h02);
    xfer({20'hA5C3E, ascc_pkg::ASCC_OP_WR, 9'h01C, 8'h15}, 40);
    check("chain", r[19:0], 20'hA5C3E);
    rdchk(9'h01C, 8'h15);
    xfer({20'h0, ascc_pkg::ASCC_OP_WR, 9'h01C, 8'h2A}, 19);
    rdchk(9'h01C, 8'h15);
    res = 18'h2D4B7;
    conv_q = 1'b1;
    xfer(40'h0, 20);
    check("sample", r[19:0], {res, 2'b00});
    tie = 1'b1;
    res = 18'h1E0F1;
    xfer(40'h0, 20);
    xfer(40'h0, 20);
    check("tied", r[19:0], {18'h1E0F1, 2'b00});
    rst_n_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    check("rereset", {6'h0, sdo_oe, ready, sleep, power_down_bit, omode, wcfg}, 20'h01000);
    repeat (4) begin
      @(negedge clk_i);
      check("no sample", {19'h0, sample}, 20'h0);
    end
    finish_test();
  end
endmodule
bind ascc_port ascc_port_sva u_sva (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i),
  .conv_start_i(conv_start_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .ready_strobe_out_o(ready_strobe_out_o),
  .sample_o(sample_o), .light_sleep_enable_o(light_sleep_enable_o), .power_down_bit_o(power_down_bit_o),
  .output_mode_field_o(output_mode_field_o), .output_word_config_o(output_word_config_o));
